// >>> rtl/sdc_pkg.sv
package sdc_pkg;

  // Fixed capability words returned by the parameter read command.
  localparam logic [31:0] SDC_CAP_WIDGET = 32'h0004061d;
  localparam logic [31:0] SDC_CAP_PCM    = 32'h000e05e0;
  localparam logic [31:0] SDC_CAP_STREAM = 32'h00000005;
  localparam logic [31:0] SDC_CAP_AMP    = 32'h80000000;

  // Parameter identifiers carried in the payload of the parameter read.
  localparam logic [7:0] SDC_PAR_WIDGET = 8'h09;
  localparam logic [7:0] SDC_PAR_PCM    = 8'h0a;
  localparam logic [7:0] SDC_PAR_STREAM = 8'h0b;
  localparam logic [7:0] SDC_PAR_AMP    = 8'h12;

  // Short command codes with a 16-bit payload.
  localparam logic [3:0] SDC_V4_SET_FMT = 4'h2;
  localparam logic [3:0] SDC_V4_SET_AMP = 4'h3;
  localparam logic [3:0] SDC_V4_GET_FMT = 4'ha;
  localparam logic [3:0] SDC_V4_GET_AMP = 4'hb;

  // Long command codes with an 8-bit payload.
  localparam logic [11:0] SDC_V_GET_PARAM = 12'hf00;
  localparam logic [11:0] SDC_V_SET_PWR   = 12'h705;
  localparam logic [11:0] SDC_V_GET_PWR   = 12'hf05;
  localparam logic [11:0] SDC_V_SET_BIND  = 12'h706;
  localparam logic [11:0] SDC_V_GET_BIND  = 12'hf06;
  localparam logic [11:0] SDC_V_SET_DIG1  = 12'h70d;
  localparam logic [11:0] SDC_V_SET_DIG2  = 12'h70e;
  localparam logic [11:0] SDC_V_SET_DIG3  = 12'h73e;
  localparam logic [11:0] SDC_V_SET_DIG4  = 12'h73f;
  localparam logic [11:0] SDC_V_GET_DIG1  = 12'hf0d;
  localparam logic [11:0] SDC_V_GET_DIG2  = 12'hf0e;

  // Bit positions inside the amplifier command payload.
  localparam int SDC_AMP_OUT_BIT   = 15;
  localparam int SDC_AMP_LEFT_BIT  = 13;
  localparam int SDC_AMP_RIGHT_BIT = 12;
  localparam int SDC_AMP_MUTE_BIT  = 7;

  // Values after reset, and the D0 power-state code.
  localparam logic [2:0] SDC_SIZE_RST = 3'h3;
  localparam logic [3:0] SDC_NCH_RST  = 4'h1;
  localparam logic [1:0] SDC_PWR_D0   = 2'h0;
  localparam logic [1:0] SDC_PWR_D3   = 2'h3;

  // Stream format word; the layout fixes every field position.
  typedef struct packed {
    logic       non_pcm_select;
    logic       base_rate_select;
    logic [2:0] rate_multiplier;
    logic [2:0] rate_divider;
    logic       rsvd;
    logic [2:0] sample_size_code;
    logic [3:0] channel_count_minus_one;
  } sdc_fmt_t;

  // Channel-status and enable word of the digital output control.
  typedef struct packed {
    logic       keep_clocking_in_d3;
    logic [7:0] rsvd;
    logic [6:0] category_code;
    logic       generation_level;
    logic       professional_flag;
    logic       non_audio;
    logic       copyright;
    logic       preemphasis;
    logic       validity_config;
    logic       validity;
    logic       converter_on;
  } sdc_dig_t;

  // Programmed converter settings handed to the datapath.
  typedef struct packed {
    sdc_fmt_t   fmt;
    logic       mute_left;
    logic       mute_right;
    logic [1:0] power_request;
    logic [3:0] stream_id;
    logic [3:0] first_channel;
    sdc_dig_t   dig;
  } sdc_cfg_t;

  // Core-domain state.
  typedef struct packed {
    logic        req_s1;
    logic        req_s2;
    logic        req_seen;
    logic        ack;
    logic [31:0] rsp;
    sdc_cfg_t    cfg;
    logic [1:0]  power_actual;
    logic        power_error;
    logic        settings_were_reset;
    logic        active;
    logic        clock_keep;
    logic [3:0]  second_channel;
  } sdc_core_t;

  // Link-domain state.
  typedef struct packed {
    logic [19:0] cmd;
    logic        req;
    logic        ack_s1;
    logic        ack_s2;
    logic        ack_seen;
    logic        busy;
    logic        rsp_valid;
    logic [31:0] rsp;
  } sdc_link_t;

endpackage

// >>> rtl/sdc_converter.sv
`timescale 1ns/1ps

////////////////////////////////////////////////////////////////////////////////
// Contract
// - Capability reports output converter, four-sample delay
// - Capability flags: power, digital, stereo, overrides, amp
// - Sample sizes 16, 20, 24 supported only
// - Rates 44.1, 48, 88.2, 96, 192 only
// - PCM and compressed bitstream yes, float no
// - Amp capability: mute only, no gain
// - Stream type and base rate bits, reset zero
// - Rate multiplier codes x1 to x4
// - Rate divider codes divide one to eight
// - Sample size code, resets to 24-bit
// - Channel count minus one, resets two channels
// - Left and right mute bits, reset unmuted
// - Requested and actual power, reset lowest power
// - Settings-reset flag, cleared by power read or set
// - Power error flag when state unreachable
// - Stream id zero turns converter off
// - First channel and next one form pair
// - Keep-alive keeps clocking in D3
// - Channel-status settings writable, reset zero
// - Digital enable turns converter on in D0
module sdc_converter
  import sdc_pkg::*;
(
  input  wire logic        clock_i,
  input  wire logic        rst_i,
  input  wire logic        fg_reset_i,
  input  wire logic        link_reset_i,
  input  wire logic        bit_clock_i,
  input  wire logic        cmd_valid_i,
  input  wire logic [19:0] cmd_verb_i,
  output logic             cmd_busy_o,
  output logic             rsp_valid_o,
  output logic [31:0]      rsp_data_o,
  output sdc_cfg_t         cfg_o,
  output logic [1:0]       power_actual_o,
  output logic [3:0]       second_channel_o,
  output logic             converter_active_o,
  output logic             clock_keep_o
);

  sdc_core_t core;
  sdc_core_t next_core;
  sdc_link_t link;
  sdc_link_t next_link;
  logic      link_rst_s1;
  logic      link_rst;

  //////////////////////////////////////////////////////////////////////////////
  // Link-domain reset: asserts at once, releases two bit-clock edges later.
  always_ff @(posedge bit_clock_i or posedge rst_i) begin
    if (rst_i) begin
      link_rst_s1 <= 1'b1;
      link_rst    <= 1'b1;
    end else begin
      link_rst_s1 <= 1'b0;
      link_rst    <= link_rst_s1;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Link side: one command is held until the core has answered it.
  always_comb begin
    next_link           = link;
    next_link.ack_s1    = core.ack;
    next_link.ack_s2    = link.ack_s1;
    next_link.rsp_valid = 1'b0;
    if (link.ack_s2 != link.ack_seen) begin
      // The core answer is stable while the acknowledge toggle crosses.
      next_link.ack_seen  = link.ack_s2;
      next_link.rsp       = core.rsp;
      next_link.rsp_valid = 1'b1;
      next_link.busy      = 1'b0;
    end else if (!link.busy && cmd_valid_i) begin
      next_link.cmd  = cmd_verb_i;
      next_link.req  = ~link.req;
      next_link.busy = 1'b1;
    end
  end

  // Registers the link-domain state.
  always_ff @(posedge bit_clock_i or posedge link_rst) begin
    if (link_rst) begin
      link <= '0;
    end else begin
      link <= next_link;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Command decode in the core domain.
  logic        exec;
  logic [3:0]  v4;
  logic [11:0] v12;
  logic [15:0] pay16;
  logic [7:0]  pay8;
  logic        short_form;
  logic        is_set;
  logic        is_get_pwr;

  // The command register is stable while the request toggle is pending.
  always_comb begin
    exec       = core.req_s2 != core.req_seen;
    v4         = link.cmd[19:16];
    v12        = link.cmd[19:8];
    pay16      = link.cmd[15:0];
    pay8       = link.cmd[7:0];
    short_form = (v4 == SDC_V4_SET_FMT) || (v4 == SDC_V4_SET_AMP) ||
                 (v4 == SDC_V4_GET_FMT) || (v4 == SDC_V4_GET_AMP);
    is_set     = (short_form && (v4 == SDC_V4_SET_FMT || v4 == SDC_V4_SET_AMP)) ||
                 (!short_form && (v12 == SDC_V_SET_PWR || v12 == SDC_V_SET_BIND ||
                                  v12 == SDC_V_SET_DIG1 || v12 == SDC_V_SET_DIG2 ||
                                  v12 == SDC_V_SET_DIG3 || v12 == SDC_V_SET_DIG4));
    is_get_pwr = !short_form && (v12 == SDC_V_GET_PWR);
  end

  //////////////////////////////////////////////////////////////////////////////
  // Core next-state: settings, answers and derived converter controls.
  always_comb begin
    next_core          = core;
    next_core.req_s1   = link.req;
    next_core.req_s2   = core.req_s1;
    if (exec) begin
      next_core.req_seen = core.req_s2;
      next_core.ack      = ~core.ack;
      next_core.rsp      = '0;  // Reserved bits and unknown commands read zero.
      if (short_form) begin
        case (v4)
          SDC_V4_SET_FMT: begin
            next_core.cfg.fmt      = sdc_fmt_t'(pay16);
            next_core.cfg.fmt.rsvd = 1'b0;
          end
          SDC_V4_SET_AMP: begin
            if (pay16[SDC_AMP_OUT_BIT] && pay16[SDC_AMP_LEFT_BIT]) begin
              next_core.cfg.mute_left = pay16[SDC_AMP_MUTE_BIT];
            end
            if (pay16[SDC_AMP_OUT_BIT] && pay16[SDC_AMP_RIGHT_BIT]) begin
              next_core.cfg.mute_right = pay16[SDC_AMP_MUTE_BIT];
            end
          end
          SDC_V4_GET_FMT: begin
            next_core.rsp[15:0] = core.cfg.fmt;
          end
          SDC_V4_GET_AMP: begin
            if (pay16[SDC_AMP_OUT_BIT]) begin
              next_core.rsp[SDC_AMP_MUTE_BIT] = pay16[SDC_AMP_LEFT_BIT] ?
                                                core.cfg.mute_left : core.cfg.mute_right;
            end
          end
          default: begin
            next_core.rsp = '0;
          end
        endcase
      end else begin
        case (v12)
          SDC_V_GET_PARAM: begin
            case (pay8)
              SDC_PAR_WIDGET: next_core.rsp = SDC_CAP_WIDGET;
              SDC_PAR_PCM:    next_core.rsp = SDC_CAP_PCM;
              SDC_PAR_STREAM: next_core.rsp = SDC_CAP_STREAM;
              SDC_PAR_AMP:    next_core.rsp = SDC_CAP_AMP;
              default:        next_core.rsp = '0;
            endcase
          end
          SDC_V_SET_PWR: begin
            next_core.cfg.power_request = pay8[1:0];
          end
          SDC_V_GET_PWR: begin
            next_core.rsp[10]  = core.settings_were_reset;
            next_core.rsp[8]   = core.power_error;
            next_core.rsp[5:4] = core.power_actual;
            next_core.rsp[1:0] = core.cfg.power_request;
          end
          SDC_V_SET_BIND: begin
            next_core.cfg.stream_id     = pay8[7:4];
            next_core.cfg.first_channel = pay8[3:0];
          end
          SDC_V_GET_BIND: begin
            next_core.rsp[7:0] = {core.cfg.stream_id, core.cfg.first_channel};
          end
          SDC_V_SET_DIG1: begin
            next_core.cfg.dig[7:0] = pay8;
          end
          SDC_V_SET_DIG2: begin
            next_core.cfg.dig.category_code = pay8[6:0];
          end
          SDC_V_SET_DIG3: begin
            next_core.cfg.dig.keep_clocking_in_d3 = pay8[7];
          end
          SDC_V_SET_DIG4: begin
            next_core.cfg = core.cfg;  // Top byte is reserved; the write is dropped.
          end
          SDC_V_GET_DIG1, SDC_V_GET_DIG2: begin
            next_core.rsp[23:0] = core.cfg.dig;
          end
          default: begin
            next_core.rsp = '0;
          end
        endcase
      end
      // A read of the power word or any set command clears the reset flag.
      if (is_set || is_get_pwr) begin
        next_core.settings_were_reset = 1'b0;
      end
    end
    // Link reset returns the power and binding fields to their defaults.
    if (link_reset_i) begin
      next_core.cfg.power_request = SDC_PWR_D3;
      next_core.cfg.stream_id     = '0;
      next_core.cfg.first_channel = '0;
    end
    // Function-group reset restores every persistent setting; set beats clear.
    if (fg_reset_i) begin
      next_core.cfg                      = '0;
      next_core.cfg.fmt.sample_size_code = SDC_SIZE_RST;
      next_core.cfg.fmt.channel_count_minus_one = SDC_NCH_RST;
      next_core.cfg.power_request        = SDC_PWR_D3;
      next_core.settings_were_reset      = 1'b1;
    end
    // Every requested state D0 to D3 is reachable, so no error is raised.
    next_core.power_actual   = core.cfg.power_request;
    next_core.power_error    = 1'b0;
    next_core.second_channel = 4'(core.cfg.first_channel + 4'h1);
    next_core.active         = core.cfg.dig.converter_on &&
                               (core.cfg.stream_id != 4'h0) &&
                               (core.power_actual == SDC_PWR_D0);
    next_core.clock_keep     = (core.power_actual != SDC_PWR_D3) ||
                               core.cfg.dig.keep_clocking_in_d3;
  end

  // Registers the core state; reset loads the documented defaults.
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      core                                   <= '0;
      core.cfg.fmt.sample_size_code          <= SDC_SIZE_RST;
      core.cfg.fmt.channel_count_minus_one   <= SDC_NCH_RST;
      core.cfg.power_request                 <= SDC_PWR_D3;
      core.power_actual                      <= SDC_PWR_D3;
      core.settings_were_reset               <= 1'b1;
      core.second_channel                    <= 4'h1;
    end else begin
      core <= next_core;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Outputs come straight from the state registers.
  assign cmd_busy_o         = link.busy;
  assign rsp_valid_o        = link.rsp_valid;
  assign rsp_data_o         = link.rsp;
  assign cfg_o              = core.cfg;
  assign power_actual_o     = core.power_actual;
  assign second_channel_o   = core.second_channel;
  assign converter_active_o = core.active;
  assign clock_keep_o       = core.clock_keep;

  //////////////////////////////////////////////////////////////////////////////
  // Checks on the core domain.
  property p_widget_word;
    @(posedge clock_i) disable iff (rst_i)
      exec && !short_form && v12 == SDC_V_GET_PARAM && pay8 == SDC_PAR_WIDGET
      |=> core.rsp[23:16] == 8'h04 && core.rsp[10:8] == 3'b110 && core.rsp[4:0] == 5'h1d;
  endproperty
  a_widget_word: assert property (p_widget_word) else $error("Widget word wrong");

  property p_pcm_word;
    @(posedge clock_i) disable iff (rst_i)
      exec && !short_form && v12 == SDC_V_GET_PARAM && pay8 == SDC_PAR_PCM
      |=> core.rsp[20:16] == 5'h0e && core.rsp[11:0] == 12'h5e0;
  endproperty
  a_pcm_word: assert property (p_pcm_word) else $error("PCM word wrong");

  property p_fg_defaults;
    @(posedge clock_i) disable iff (rst_i)
      fg_reset_i |=> core.cfg.fmt.sample_size_code == 3'h3 &&
                     core.cfg.fmt.channel_count_minus_one == 4'h1 &&
                     !core.cfg.fmt.non_pcm_select && !core.cfg.mute_left;
  endproperty
  a_fg_defaults: assert property (p_fg_defaults) else $error("Defaults wrong");

  property p_power_follow;
    @(posedge clock_i) disable iff (rst_i)
      exec && !short_form && v12 == SDC_V_SET_PWR && !fg_reset_i && !link_reset_i
      |=> ##1 core.power_actual == $past(pay8[1:0], 2);
  endproperty
  a_power_follow: assert property (p_power_follow) else $error("Power mismatch");

  property p_flag_set;
    @(posedge clock_i) disable iff (rst_i)
      fg_reset_i |=> core.settings_were_reset;
  endproperty
  a_flag_set: assert property (p_flag_set) else $error("Flag not set");

  property p_flag_clear;
    @(posedge clock_i) disable iff (rst_i)
      exec && is_set && !fg_reset_i |=> !core.settings_were_reset;
  endproperty
  a_flag_clear: assert property (p_flag_clear) else $error("Flag not cleared");

  property p_stream_off;
    @(posedge clock_i) disable iff (rst_i)
      core.cfg.stream_id == 4'h0 |=> !converter_active_o;
  endproperty
  a_stream_off: assert property (p_stream_off) else $error("Active with id 0");

  property p_enable_gate;
    @(posedge clock_i) disable iff (rst_i)
      !core.cfg.dig.converter_on ##1 !core.cfg.dig.converter_on |-> !converter_active_o;
  endproperty
  a_enable_gate: assert property (p_enable_gate) else $error("Active while off");

  property p_mute_write;
    @(posedge clock_i) disable iff (rst_i)
      exec && short_form && v4 == SDC_V4_SET_AMP && pay16[15] && pay16[13] && !fg_reset_i
      |=> cfg_o.mute_left == $past(pay16[7]);
  endproperty
  a_mute_write: assert property (p_mute_write) else $error("Mute not stored");

  property p_keep_d3;
    @(posedge clock_i) disable iff (rst_i)
      core.power_actual == 2'h3 && !core.cfg.dig.keep_clocking_in_d3 |=> !clock_keep_o;
  endproperty
  a_keep_d3: assert property (p_keep_d3) else $error("Clock kept in D3");

  property p_pair;
    @(posedge clock_i) disable iff (rst_i)
      1'b1 |=> second_channel_o == 4'($past(core.cfg.first_channel) + 4'h1);
  endproperty
  a_pair: assert property (p_pair) else $error("Pair channel wrong");

  property p_stream_word;
    @(posedge clock_i) disable iff (rst_i)
      exec && !short_form && v12 == SDC_V_GET_PARAM && pay8 == SDC_PAR_STREAM
      |=> core.rsp == 32'h00000005;
  endproperty
  a_stream_word: assert property (p_stream_word) else $error("Stream word wrong");

  property p_amp_word;
    @(posedge clock_i) disable iff (rst_i)
      exec && !short_form && v12 == SDC_V_GET_PARAM && pay8 == SDC_PAR_AMP
      |=> core.rsp == 32'h80000000;
  endproperty
  a_amp_word: assert property (p_amp_word) else $error("Amp word wrong");

  property p_error_clear;
    @(posedge clock_i) disable iff (rst_i)
      exec && is_get_pwr |=> !core.rsp[8] && core.rsp[9] == 1'b0;
  endproperty
  a_error_clear: assert property (p_error_clear) else $error("Power error raised");

  property p_fmt_rsvd;
    @(posedge clock_i) disable iff (rst_i)
      exec && short_form && v4 == SDC_V4_SET_FMT |=> !core.cfg.fmt.rsvd;
  endproperty
  a_fmt_rsvd: assert property (p_fmt_rsvd) else $error("Reserved format bit set");

  property p_dig_defaults;
    @(posedge clock_i) disable iff (rst_i)
      fg_reset_i |=> core.cfg.dig == 24'h000000;
  endproperty
  a_dig_defaults: assert property (p_dig_defaults) else $error("Digital word not reset");

  property p_bind_write;
    @(posedge clock_i) disable iff (rst_i)
      exec && !short_form && v12 == SDC_V_SET_BIND && !fg_reset_i && !link_reset_i
      |=> core.cfg.stream_id == $past(pay8[7:4]);
  endproperty
  a_bind_write: assert property (p_bind_write) else $error("Stream id not stored");

  property p_lr_defaults;
    @(posedge clock_i) disable iff (rst_i)
      link_reset_i |=> core.cfg.power_request == 2'h3 && core.cfg.stream_id == 4'h0;
  endproperty
  a_lr_defaults: assert property (p_lr_defaults) else $error("Link reset defaults wrong");

endmodule

// >>> verif/sdc_host_model.sv
`timescale 1ns/1ps

////////////////////////////////////////////////////////////////////////////////
// Host side of the command link: it sends one command and waits for its answer.
module sdc_host_model (
  input  wire logic        bit_clock_i,
  input  wire logic        cmd_busy_i,
  input  wire logic        rsp_valid_i,
  input  wire logic [31:0] rsp_data_i,
  output logic             cmd_valid_o,
  output logic [19:0]      cmd_verb_o
);

  // The link is idle from time zero.
  initial begin
    cmd_valid_o = 1'b0;
    cmd_verb_o  = 20'h00000;
  end

  // Offers a command, holds it to the taking edge, then takes the answer at its edge.
  task automatic send(input logic [19:0] verb, output logic [31:0] data, output logic ok);
    int n;
    ok   = 1'b0;
    data = 32'h00000000;
    @(posedge bit_clock_i);
    #1;
    cmd_valid_o = 1'b1;
    cmd_verb_o  = verb;
    for (n = 0; n < 20; n++) begin
      @(posedge bit_clock_i);
      if (cmd_busy_i === 1'b0) break;
    end
    #1;
    cmd_valid_o = 1'b0;
    cmd_verb_o  = ~verb; // A released command bus must not keep its last value.
    for (n = 0; n < 20 && !ok; n++) begin
      @(posedge bit_clock_i);
      if (rsp_valid_i === 1'b1) begin
        data = rsp_data_i;
        ok   = 1'b1;
      end
    end
  endtask

endmodule

// >>> verif/tb_spdif_output_converter_widget.sv
`timescale 1ns/1ps

module tb_spdif_output_converter_widget import sdc_pkg::*;;

  logic        clock_i;
  logic        rst_i;
  logic        fg_reset_i;
  logic        link_reset_i;
  logic        bit_clock_i;
  logic        cmd_valid_i;
  logic [19:0] cmd_verb_i;
  logic        cmd_busy_o;
  logic        rsp_valid_o;
  logic [31:0] rsp_data_o;
  sdc_cfg_t    cfg_o;
  logic [1:0]  power_actual_o;
  logic [3:0]  second_channel_o;
  logic        converter_active_o;
  logic        clock_keep_o;
  int          miscompares;
  int          n_checks;
  int          i;
  logic [31:0] d;
  logic [15:0] f;
  logic [15:0] fexp;
  logic [3:0]  s;
  logic [3:0]  c;
  logic [7:0]  b1;
  logic [7:0]  b2;

  sdc_converter i_sdc_converter (
    .clock_i            (clock_i),
    .rst_i              (rst_i),
    .fg_reset_i         (fg_reset_i),
    .link_reset_i       (link_reset_i),
    .bit_clock_i        (bit_clock_i),
    .cmd_valid_i        (cmd_valid_i),
    .cmd_verb_i         (cmd_verb_i),
    .cmd_busy_o         (cmd_busy_o),
    .rsp_valid_o        (rsp_valid_o),
    .rsp_data_o         (rsp_data_o),
    .cfg_o              (cfg_o),
    .power_actual_o     (power_actual_o),
    .second_channel_o   (second_channel_o),
    .converter_active_o (converter_active_o),
    .clock_keep_o       (clock_keep_o)
  );

  sdc_host_model i_sdc_host_model (
    .bit_clock_i (bit_clock_i),
    .cmd_busy_i  (cmd_busy_o),
    .rsp_valid_i (rsp_valid_o),
    .rsp_data_i  (rsp_data_o),
    .cmd_valid_o (cmd_valid_i),
    .cmd_verb_o  (cmd_verb_i)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // Core clock of 10 ns and a free-running link clock of 80 ns.
  initial begin
    clock_i     = 1'b0;
    bit_clock_i = 1'b0;
  end
  always #5 clock_i = ~clock_i;
  always #40 bit_clock_i = ~bit_clock_i;

  ////////////////////////////////////////////////////////////////////////////////
  // Compares one value and counts it.
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask

  // Sends one command; a missing answer counts as a mismatch.
  task automatic cmd(input logic [19:0] verb, output logic [31:0] data);
    logic ok;
    i_sdc_host_model.send(verb, data, ok);
    if (ok !== 1'b1) begin
      miscompares++;
      $display("MISMATCH answer to %h expected 1 seen 0", verb);
    end
  endtask

  // Sends a read command and compares its answer.
  task automatic rd(input logic [19:0] verb, input logic [31:0] exp);
    logic [31:0] r;
    cmd(verb, r);
    chk($sformatf("read %h", verb), exp, r);
  endtask

  // Pulses the function-group reset for one core cycle.
  task automatic pulse_fg();
    @(posedge clock_i);
    #1 fg_reset_i = 1'b1;
    @(posedge clock_i);
    #1 fg_reset_i = 1'b0;
  endtask

  // Power word: settings flag, error clear, actual and requested state.
  function automatic logic [31:0] pwr(input logic flag, input logic [1:0] act,
                                      input logic [1:0] req);
    return {21'h0, flag, 1'b0, 1'b0, 2'h0, act, 2'h0, req};
  endfunction

  // Prints the verdict and ends the run.
  task automatic summarize();
    if (miscompares == 0 && n_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  // Cuts a hung run short.
  initial begin
    #500000;
    miscompares++;
    summarize();
  end

  // Main sequence.
  initial begin
    rst_i        = 1'b1;
    fg_reset_i   = 1'b0;
    link_reset_i = 1'b0;
    miscompares  = 0;
    n_checks     = 0;
    void'($urandom(3283));
    repeat (20) @(posedge clock_i);
    #1 rst_i = 1'b0;
    repeat (4) @(posedge bit_clock_i);
    rd(20'ha0000, 32'h00000031);
    rd(20'hf0500, pwr(1'b1, 2'h3, 2'h3));
    rd(20'hf0500, pwr(1'b0, 2'h3, 2'h3));
    rd(20'hba000, 32'h0);
    rd(20'hb8000, 32'h0);
    rd(20'hf0600, 32'h0);
    rd(20'hf0d00, 32'h0);
    rd(20'hf0009, (32'h4 << 16) | 32'h400 | 32'h200 | 32'h01c | 32'h001);
    rd(20'hf000a, (32'h7 << 17) | 32'h400 | (32'hf << 5));
    rd(20'hf000b, 32'h1 | 32'h4);
    rd(20'hf0012, 32'h1 << 31);
    rd(20'hf0700, 32'h0);
    // Format words cover every multiplier, divider and size code.
    for (i = 0; i < 10; i++) begin
      f = 16'($urandom());
      if (i < 8) f[13:8] = {3'(i % 4), 3'(i)};
      else f[13:11] = 3'($urandom_range(3));
      f[6:4] = 3'(i % 5);
      fexp = f & 16'hff7f;
      cmd({4'h2, f}, d);
      rd(20'ha0000, {16'h0, fexp});
      chk("cfg_o.fmt", {16'h0, fexp}, {16'h0, 16'(cfg_o.fmt)});
    end
    // Mute each side alone; reserved low bits stay zero.
    cmd(20'h3a080, d);
    rd(20'hba000, 32'h80);
    rd(20'hb8000, 32'h0);
    chk("cfg_o.mute_left", 32'h1, {31'h0, cfg_o.mute_left});
    cmd(20'h390ff, d);
    rd(20'hb8000, 32'h80);
    cmd(20'h3a000, d);
    rd(20'hba000, 32'h0);
    // Every power state is reachable; reserved payload bits are ignored.
    for (i = 0; i < 4; i++) begin
      cmd({12'h705, 8'(i) | 8'hfc}, d);
      rd(20'hf0500, pwr(1'b0, 2'(i), 2'(i)));
      chk("power_actual_o", 32'(i), {30'h0, power_actual_o});
      chk("clock_keep_o", {31'h0, i != 3}, {31'h0, clock_keep_o});
    end
    cmd(20'h73eff, d);
    chk("clock_keep_o", 32'h1, {31'h0, clock_keep_o});
    b1 = 8'($urandom()) | 8'h01;
    b2 = 8'($urandom());
    cmd({12'h70d, b1}, d);
    cmd({12'h70e, b2}, d);
    cmd(20'h73fff, d);
    rd(20'hf0d00, {8'h00, 8'h80, b2 & 8'h7f, b1});
    rd(20'hf0e00, {8'h00, 8'h80, b2 & 8'h7f, b1});
    chk("cfg_o.dig", {8'h00, 8'h80, b2 & 8'h7f, b1}, {8'h00, 24'(cfg_o.dig)});
    // Binding in D0 with the converter on; the last pass turns the stream off.
    cmd(20'h70500, d);
    for (i = 0; i < 3; i++) begin
      s = (i == 2) ? 4'h0 : 4'($urandom_range(15, 1));
      c = (i == 0) ? 4'hf : 4'($urandom());
      cmd({12'h706, s, c}, d);
      rd(20'hf0600, {24'h0, s, c});
      chk("second_channel_o", {28'h0, c + 4'h1}, {28'h0, second_channel_o});
      chk("converter_active_o", {31'h0, s != 4'h0}, {31'h0, converter_active_o});
    end
    cmd(20'h70651, d);
    cmd({12'h70d, b1 & 8'hfe}, d);
    chk("converter_active_o", 32'h0, {31'h0, converter_active_o});
    // Link reset clears the binding and requests D3 but keeps the format.
    @(posedge clock_i);
    #1 link_reset_i = 1'b1;
    @(posedge clock_i);
    #1 link_reset_i = 1'b0;
    rd(20'hf0600, 32'h0);
    rd(20'ha0000, {16'h0, fexp});
    chk("cfg_o.power_request", 32'h3, {30'h0, cfg_o.power_request});
    // Function-group reset restores defaults and raises the settings flag.
    pulse_fg();
    rd(20'ha0000, 32'h00000031);
    rd(20'hb8000, 32'h0);
    rd(20'hf0d00, 32'h0);
    rd(20'hf0500, pwr(1'b1, 2'h3, 2'h3));
    pulse_fg();
    cmd(20'h20011, d);
    rd(20'hf0500, pwr(1'b0, 2'h3, 2'h3));
    summarize();
  end

endmodule
